// File: hdl/sdh_pkg.sv
// Functional notes
// - one card selected while data move
// - one data command outstanding at once
// - refill fifo, restart clock, then stop
// - reset fifo before resume command
// - reset command mid transfer sets stop flag
// - end-bit error: ignore sdio, send stop
// - two fifo reads restart stalled read clock; here one read per rx request, no read stall tracked
// - one ce-ata device addressed at once
// - no second ce-ata block command, except disable
// - interrupts disabled allows status commands
// - ce-ata: no stream, no automatic stop
// - locked registers untouched until command issued
package sdh_pkg;
  // own register byte offsets
  localparam logic [7:0] REG_ORDER = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_BYTES = 8'h08;
  localparam logic [7:0] REG_BLKSZ = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_TXW = 8'h14;
  localparam logic [7:0] REG_RXW = 8'h18;
  // order word fields (index is six bits at OF_IDX)
  localparam int OF_IDX = 0;
  localparam int OF_DATA = 6;
  localparam int OF_WRITE = 7;
  localparam int OF_STREAM = 8;
  localparam int OF_ASTOP = 9;
  localparam int OF_CARD = 10;
  localparam int OF_CEATA = 11;
  localparam int OF_DEVICE_INTERRUPT_DISABLE = 12;
  localparam int OF_RESUME = 13;
  localparam int OF_IORST = 14;
  localparam int OF_RWBLK = 15;
  localparam int OF_COMPLETION_SIGNAL_DISABLE = 16;
  // status word fields
  localparam int ST_BUSY = 0;
  localparam int ST_DATA = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_NOSDIO = 3;
  localparam int ST_DTO = 4;
  localparam int ST_TXPEND = 5;
  localparam int ST_RXVALID = 6;
  localparam int ST_SDIO = 7;
  localparam int ST_DONE = 8;
  localparam int ST_CARD = 9;
  // device register byte offsets
  localparam logic [7:0] DEV_CTRL = 8'h00;
  localparam logic [7:0] DEV_CLKENA = 8'h04;
  localparam logic [7:0] DEV_ARG = 8'h08;
  localparam logic [7:0] DEV_BYTES = 8'h0C;
  localparam logic [7:0] DEV_BLKSZ = 8'h10;
  localparam logic [7:0] DEV_CMD = 8'h14;
  localparam logic [7:0] DEV_RAW = 8'h18;
  localparam logic [7:0] DEV_FIFO = 8'h1C;
  // device command and control fields
  localparam int DC_DATA = 9;
  localparam int DC_WRITE = 10;
  localparam int DC_STREAM = 11;
  localparam int DC_ASTOP = 12;
  localparam int DC_STOP = 14;
  localparam int DC_CARD = 16;
  localparam int DC_START = 31;
  localparam int DCTL_FIFO_RST = 1;
  // device raw status fields
  localparam int DS_DONE = 3;
  localparam int DS_TXREQ = 4;
  localparam int DS_RXREQ = 5;
  localparam int DS_RTO = 8;
  localparam int DS_DRTO = 9;
  localparam int DS_EBE = 15;
  localparam int DS_SDIO = 16;
  localparam int DS_TXSTALL = 17;
  localparam logic [31:0] DS_CLR_MASK = 32'h0001_8308;
  // card command indices
  localparam logic [5:0] CMD_GO_IDLE = 6'h00;
  localparam logic [5:0] CMD_STOP = 6'h0C;
  localparam logic [5:0] CMD_INACTIVE = 6'h0F;
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_FRST = 4'b0001, S_ARG = 4'b0010, S_BYT = 4'b0011,
    S_BLK = 4'b0100, S_CMD = 4'b0101, S_LOCK = 4'b0110, S_POLL = 4'b0111,
    S_CLR = 4'b1000, S_TXW = 4'b1001, S_RXW = 4'b1010, S_CKEN = 4'b1011
  } sdh_state_t;
endpackage

// File: hdl/sdh_ctrl.sv
`timescale 1ns/1ps
module sdh_ctrl import sdh_pkg::*; #(
  parameter int DEV_AW = 8 // device register address width
) (
  input wire logic core_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic wb_cyc, // wishbone cycle
  input wire logic wb_stb, // wishbone strobe
  input wire logic wb_we, // wishbone write
  input wire logic [7:0] wb_adr, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  input wire logic [3:0] wb_sel, // wishbone byte lanes
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack, // wishbone acknowledge
  output logic dev_req, // device register request
  output logic dev_we, // device register write
  output logic [DEV_AW-1:0] dev_addr, // device register address
  output logic [31:0] dev_wdata, // device write data
  input wire logic [31:0] dev_rdata, // device read data
  input wire logic dev_ack // device answer
);
  if (DEV_AW < 8) begin : g_aw_check
    $error("DEV_AW must be at least 8");
  end

  sdh_state_t state; // sequencer state
  logic ord_pend, ord_data, ord_write, ord_stream, ord_astop; // pending order
  logic ord_card, ord_stop, ord_resume, ord_blk; // order attributes
  logic [5:0] ord_idx; // order command index
  logic [31:0] stg_arg, stg_bytes, stg_blksz; // staged parameters
  logic data_active, act_card, ceata_blk, no_sdio; // transfer state
  logic refused, dto_f, sdio_f, done_f; // sticky flags
  logic tx_pend, rx_valid, rx_avail, tx_stalled, refilled; // fifo handling
  logic [31:0] tx_word, rx_word, raw_clr; // data and clear words

  // device register chosen by state
  function automatic logic [7:0] dev_reg_of(input sdh_state_t st);
    case (st)
      S_FRST: dev_reg_of = DEV_CTRL;
      S_ARG: dev_reg_of = DEV_ARG;
      S_BYT: dev_reg_of = DEV_BYTES;
      S_BLK: dev_reg_of = DEV_BLKSZ;
      S_CMD, S_LOCK: dev_reg_of = DEV_CMD;
      S_POLL, S_CLR: dev_reg_of = DEV_RAW;
      S_CKEN: dev_reg_of = DEV_CLKENA;
      default: dev_reg_of = DEV_FIFO;
    endcase
  endfunction

  // state after an answered access
  function automatic sdh_state_t next_of(input sdh_state_t st, input logic [31:0] rd);
    case (st)
      S_FRST, S_CKEN: next_of = S_ARG;
      S_ARG: next_of = S_BYT;
      S_BYT: next_of = S_BLK;
      S_BLK: next_of = S_CMD;
      S_CMD: next_of = S_LOCK;
      S_LOCK: next_of = rd[DC_START] ? S_LOCK : S_IDLE;
      S_POLL: next_of = (|(rd & DS_CLR_MASK)) ? S_CLR : S_IDLE;
      default: next_of = S_IDLE;
    endcase
  endfunction

  // wishbone decode
  wire acc = wb_cyc & wb_stb & ~wb_ack;
  wire wr = acc & wb_we & (&wb_sel);
  wire rd = acc & ~wb_we;
  wire go_wr = wr & (wb_adr == REG_ORDER);
  wire sclr_wr = wr & (wb_adr == REG_STATUS);
  wire tx_wr = wr & (wb_adr == REG_TXW);
  wire rx_rd = rd & (wb_adr == REG_RXW);
  wire stg_wr = wr & ((wb_adr == REG_ARG) | (wb_adr == REG_BYTES) | (wb_adr == REG_BLKSZ));
  wire [31:0] clr_bits = sclr_wr ? wb_dat_i : 32'h0000_0000;

  // order fields
  wire [5:0] o_idx = wb_dat_i[OF_IDX +: 6];
  wire o_data = wb_dat_i[OF_DATA];
  wire o_stream = wb_dat_i[OF_STREAM];
  wire o_astop = wb_dat_i[OF_ASTOP];
  wire o_card = wb_dat_i[OF_CARD];
  wire o_ceata = wb_dat_i[OF_CEATA];
  wire o_completion_signal_disable = wb_dat_i[OF_COMPLETION_SIGNAL_DISABLE];
  wire o_reset = (o_idx == CMD_GO_IDLE) | (o_idx == CMD_INACTIVE) | wb_dat_i[OF_IORST];
  wire o_stop = data_active & (o_reset | (o_idx == CMD_STOP));

  // device answer events
  wire ack_in = dev_req & dev_ack;
  wire lock_done = ack_in & (state == S_LOCK) & ~dev_rdata[DC_START];
  wire poll_done = ack_in & (state == S_POLL);
  wire ev_done = poll_done & dev_rdata[DS_DONE];
  wire ev_rto = poll_done & dev_rdata[DS_RTO];
  wire ev_drto = poll_done & dev_rdata[DS_DRTO];
  wire ev_ebe = poll_done & dev_rdata[DS_EBE];
  wire ev_sdio = poll_done & dev_rdata[DS_SDIO] & ~no_sdio & ~dev_rdata[DS_EBE];
  wire data_end = ev_done | ev_rto | ev_drto | (lock_done & ord_stop);

  // order refusal
  wire ref_two = o_data & data_active;
  wire ref_card = data_active & (o_card != act_card);
  wire ref_ceata = o_ceata & o_data & (o_stream | o_astop);
  wire ref_blk = ceata_blk & ~o_completion_signal_disable;
  wire refuse = ord_pend | ev_ebe | ref_two | ref_card | ref_ceata | ref_blk;
  wire take = go_wr & ~refuse;
  wire ref_set = (go_wr & refuse) | (tx_wr & tx_pend) | (stg_wr & ord_pend);

  // device command word
  wire [31:0] cmd_word = (32'(ord_data) << DC_DATA) | (32'(ord_write) << DC_WRITE) |
    (32'(ord_stream) << DC_STREAM) | (32'(ord_astop) << DC_ASTOP) |
    (32'(ord_stop) << DC_STOP) | (32'(ord_card) << DC_CARD) |
    (32'h0000_0001 << DC_START) | 32'(ord_idx);

  // idle dispatch
  wire stop_hold = ord_pend & ord_stop & tx_stalled;
  wire sdh_state_t next_state = (ord_pend & ord_resume) ? S_FRST :
    (stop_hold & refilled) ? S_CKEN :
    (ord_pend & ~stop_hold) ? S_ARG :
    tx_pend ? S_TXW :
    (data_active & rx_avail & ~rx_valid) ? S_RXW :
    data_active ? S_POLL : S_IDLE;

  // access selection
  wire st_wr = (state != S_LOCK) & (state != S_POLL) & (state != S_RXW);
  wire [7:0] sel_addr = dev_reg_of(state);
  wire [31:0] sel_data = (state == S_FRST) ? (32'h0000_0001 << DCTL_FIFO_RST) :
    (state == S_ARG) ? stg_arg :
    (state == S_BYT) ? stg_bytes :
    (state == S_BLK) ? stg_blksz :
    (state == S_CMD) ? cmd_word :
    (state == S_CLR) ? raw_clr :
    (state == S_TXW) ? tx_word :
    (state == S_CKEN) ? (32'h0000_0001 << ord_card) : 32'h0000_0000;

  // status and read mux
  wire [31:0] status_word = (32'(ord_pend) << ST_BUSY) | (32'(data_active) << ST_DATA) |
    (32'(refused) << ST_REFUSED) | (32'(no_sdio) << ST_NOSDIO) | (32'(dto_f) << ST_DTO) |
    (32'(tx_pend) << ST_TXPEND) | (32'(rx_valid) << ST_RXVALID) | (32'(sdio_f) << ST_SDIO) |
    (32'(done_f) << ST_DONE) | (32'(act_card) << ST_CARD);
  wire [31:0] rd_mux = (wb_adr == REG_ARG) ? stg_arg :
    (wb_adr == REG_BYTES) ? stg_bytes :
    (wb_adr == REG_BLKSZ) ? stg_blksz :
    (wb_adr == REG_STATUS) ? status_word :
    (wb_adr == REG_RXW) ? rx_word : 32'h0000_0000;

  // wishbone slave answers one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wb_ack <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack <= acc;
      if (rd) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // staged parameters stay frozen while an order is in flight
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stg_arg <= 32'h0000_0000;
      stg_bytes <= 32'h0000_0000;
      stg_blksz <= 32'h0000_0000;
    end else if (stg_wr & ~ord_pend) begin
      if (wb_adr == REG_ARG) stg_arg <= wb_dat_i;
      if (wb_adr == REG_BYTES) stg_bytes <= wb_dat_i;
      if (wb_adr == REG_BLKSZ) stg_blksz <= wb_dat_i;
    end
  end

  // device access sequencer: request, wait answer, drop one cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= S_IDLE;
      dev_req <= 1'b0;
      dev_we <= 1'b0;
      dev_addr <= '0;
      dev_wdata <= 32'h0000_0000;
    end else if (state == S_IDLE) begin
      state <= next_state;
    end else if (!dev_req) begin
      dev_req <= 1'b1;
      dev_we <= st_wr;
      dev_addr <= DEV_AW'(sel_addr);
      dev_wdata <= sel_data;
    end else if (dev_ack) begin
      dev_req <= 1'b0;
      state <= next_of(state, dev_rdata);
    end
  end

  // pending order; an end-bit error queues a stop of its own
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ord_pend <= 1'b0;
      ord_idx <= 6'h00;
      {ord_data, ord_write, ord_stream, ord_astop} <= 4'h0;
      {ord_card, ord_stop, ord_resume, ord_blk} <= 4'h0;
    end else if (take) begin
      ord_pend <= 1'b1;
      ord_idx <= o_idx;
      {ord_data, ord_write, ord_stream, ord_astop} <= {o_data, wb_dat_i[OF_WRITE], o_stream, o_astop};
      {ord_card, ord_stop} <= {o_card, o_stop};
      ord_resume <= wb_dat_i[OF_RESUME];
      ord_blk <= o_ceata & o_data & wb_dat_i[OF_RWBLK] & ~wb_dat_i[OF_DEVICE_INTERRUPT_DISABLE];
    end else if (ev_ebe) begin
      ord_pend <= 1'b1;
      ord_idx <= CMD_STOP;
      {ord_data, ord_write, ord_stream, ord_astop} <= 4'h0;
      {ord_stop, ord_resume, ord_blk} <= 3'b100;
    end else begin
      if (lock_done) ord_pend <= 1'b0;
      if (ack_in & (state == S_FRST)) ord_resume <= 1'b0;
    end
  end

  // transfer state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      data_active <= 1'b0;
      act_card <= 1'b0;
      ceata_blk <= 1'b0;
    end else if (lock_done & ord_data) begin
      data_active <= 1'b1;
      act_card <= ord_card;
      ceata_blk <= ord_blk;
    end else if (data_end) begin
      data_active <= 1'b0;
      ceata_blk <= 1'b0;
    end
  end

  // sticky flags: set wins over clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {refused, dto_f, sdio_f, done_f, no_sdio} <= 5'h00;
    end else begin
      refused <= ref_set | (refused & ~clr_bits[ST_REFUSED]);
      dto_f <= ev_drto | (dto_f & ~clr_bits[ST_DTO]);
      sdio_f <= ev_sdio | (sdio_f & ~clr_bits[ST_SDIO]);
      done_f <= ev_done | (done_f & ~clr_bits[ST_DONE]);
      no_sdio <= ev_ebe | (no_sdio & ~(take & o_data));
    end
  end

  // fifo words and stall tracking
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {tx_pend, rx_valid, rx_avail, tx_stalled, refilled} <= 5'h00;
      tx_word <= 32'h0000_0000;
      rx_word <= 32'h0000_0000;
      raw_clr <= 32'h0000_0000;
    end else begin
      if (tx_wr & ~tx_pend) begin
        tx_pend <= 1'b1;
        tx_word <= wb_dat_i;
      end else if (ack_in & (state == S_TXW)) begin
        tx_pend <= 1'b0;
      end
      if (ack_in & (state == S_RXW)) begin
        rx_valid <= 1'b1;
        rx_word <= dev_rdata;
      end else if (rx_rd) begin
        rx_valid <= 1'b0;
      end
      if (poll_done) begin
        rx_avail <= dev_rdata[DS_RXREQ];
        tx_stalled <= dev_rdata[DS_TXSTALL];
        raw_clr <= dev_rdata & DS_CLR_MASK;
      end else if (ack_in & (state == S_RXW)) begin
        rx_avail <= 1'b0;
      end else if (ack_in & (state == S_CKEN)) begin
        tx_stalled <= 1'b0;
      end
      if (ack_in & (state == S_TXW)) refilled <= 1'b1;
      else if (ack_in & (state == S_CKEN)) refilled <= 1'b0;
    end
  end

  wire at_cmd = (dev_addr == DEV_AW'(DEV_CMD));

  a_one_data: assert property (@(posedge core_clk) disable iff (!rstn)
    (go_wr && o_data && data_active && !ord_pend && !ev_ebe) |=> (!ord_pend && refused))
    else $error("second data order accepted");
  a_card_lock: assert property (@(posedge core_clk) disable iff (!rstn)
    (go_wr && data_active && (o_card != act_card) && !ord_pend && !ev_ebe) |=> !ord_pend)
    else $error("order to other card accepted");
  a_ceata_open: assert property (@(posedge core_clk) disable iff (!rstn)
    (go_wr && ref_ceata && !ord_pend && !ev_ebe) |=> (!ord_pend && refused))
    else $error("ce-ata stream or auto stop accepted");
  a_ceata_blk: assert property (@(posedge core_clk) disable iff (!rstn)
    (go_wr && ceata_blk && !o_completion_signal_disable && !ord_pend && !ev_ebe) |=> !ord_pend)
    else $error("order during ce-ata block command");
  a_cmd_lock: assert property (@(posedge core_clk) disable iff (!rstn)
    (ack_in && dev_we && at_cmd) |=> !dev_req ##1 (dev_req && !dev_we && at_cmd))
    else $error("command not followed by start poll");
  a_lock_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (ack_in && (state == S_LOCK) && dev_rdata[DC_START]) |=> ((state == S_LOCK) && ord_pend))
    else $error("left lock with start still set");
  a_reset_stop: assert property (@(posedge core_clk) disable iff (!rstn)
    (dev_req && dev_we && at_cmd && data_active &&
     ((dev_wdata[5:0] == CMD_GO_IDLE) || (dev_wdata[5:0] == CMD_INACTIVE)))
    |-> dev_wdata[DC_STOP])
    else $error("reset command without stop flag");
  a_stop_halt: assert property (@(posedge core_clk) disable iff (!rstn)
    (lock_done && ord_stop) |=> !data_active)
    else $error("transfer kept after stop");
  a_sdio_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(sdio_f) |-> !$past(no_sdio))
    else $error("sdio flag after end-bit error");
  a_ebe_stop: assert property (@(posedge core_clk) disable iff (!rstn)
    ev_ebe |=> (ord_pend && (ord_idx == CMD_STOP) && ord_stop))
    else $error("no stop queued after end-bit error");
  a_refill_first: assert property (@(posedge core_clk) disable iff (!rstn)
    (dev_req && dev_we && at_cmd && dev_wdata[DC_STOP]) |-> !tx_stalled)
    else $error("stop sent while write clock stalled");
  a_resume_rst: assert property (@(posedge core_clk) disable iff (!rstn)
    (ack_in && (state == S_FRST)) |=> !dev_req ##1 (dev_req && (state == S_ARG)))
    else $error("resume not issued after fifo reset");
  a_dto_end: assert property (@(posedge core_clk) disable iff (!rstn)
    ev_drto |=> (!data_active && dto_f))
    else $error("data timeout did not end transfer");
endmodule

// File: sim/sdh_card_dev.sv
`timescale 1ns/1ps
module sdh_card_dev import sdh_pkg::*; (
  input wire logic core_clk, // system clock
  input wire logic rstn, // sync reset, active low
  input wire logic dev_req, // register request
  input wire logic dev_we, // register write
  input wire logic [7:0] dev_addr, // register address
  input wire logic [31:0] dev_wdata, // write data
  output logic [31:0] dev_rdata, // read data
  output logic dev_ack, // answer pulse
  input wire logic slow, // late answers
  input wire logic ev_stb, // raise events now
  input wire logic [31:0] ev_raw, // card side events
  input wire logic [31:0] rx_word // head of receive fifo
);
  logic [31:0] arg_q, bytes_q, blk_q, cmd_q, raw_q, clkena, tx_q, rd_q, rd_val; // registers
  logic [3:0] wait_c, start_c; // answer delay, command in flight
  logic frst, rst_seen_q; // fifo reset seen before last command
  int n_cmd; // commands written
  function automatic logic [31:0] b1(input int n);
    return 32'h1 << n;
  endfunction
  // answer once the chosen delay has run
  wire hit = dev_req && !dev_ack && (wait_c == (slow ? 4'h3 : 4'h0));
  wire wr = hit && dev_we; // write lands
  wire cmd_wr = wr && dev_addr == DEV_CMD; // command launch
  wire pop = hit && !dev_we && dev_addr == DEV_FIFO; // fifo read frees an entry
  wire push = wr && dev_addr == DEV_FIFO; // fifo refill
  // written ones clear, a pop drops rx request, a refill restarts the write clock
  wire [31:0] raw_clr = (wr && dev_addr == DEV_RAW ? dev_wdata : 32'h0)
    | (pop ? b1(DS_RXREQ) : 32'h0) | (push ? b1(DS_TXSTALL) : 32'h0);
  wire fresh = cmd_wr && dev_wdata[DC_DATA]; // new data command, clean status
  // read decode
  always_comb begin
    case (dev_addr)
      DEV_CLKENA: rd_val = clkena;
      DEV_ARG: rd_val = arg_q;
      DEV_BYTES: rd_val = bytes_q;
      DEV_BLKSZ: rd_val = blk_q;
      DEV_CMD: rd_val = {start_c != 4'h0, cmd_q[30:0]};
      DEV_RAW: rd_val = raw_q;
      DEV_FIFO: rd_val = rx_word;
      default: rd_val = 32'h0;
    endcase
  end
  // a port not answering shows the inverse of the last value
  assign dev_rdata = dev_ack ? rd_q : ~rd_q;
  // registers and command timing
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {arg_q, bytes_q, blk_q, cmd_q, raw_q, clkena, tx_q, rd_q} <= '0;
      {wait_c, start_c, frst, rst_seen_q, dev_ack} <= '0;
      n_cmd <= 0;
    end else begin
      dev_ack <= hit;
      wait_c <= (dev_req && !hit && !dev_ack) ? wait_c + 4'h1 : 4'h0;
      if (hit) rd_q <= rd_val;
      if (wr && dev_addr == DEV_ARG) arg_q <= dev_wdata;
      if (wr && dev_addr == DEV_BYTES) bytes_q <= dev_wdata;
      if (wr && dev_addr == DEV_BLKSZ) blk_q <= dev_wdata;
      if (wr && dev_addr == DEV_CLKENA) clkena <= dev_wdata;
      if (push) tx_q <= dev_wdata;
      if (wr && dev_addr == DEV_CTRL && dev_wdata[DCTL_FIFO_RST]) frst <= 1'b1;
      if (cmd_wr) begin
        cmd_q <= dev_wdata;
        start_c <= dev_wdata[DC_START] ? 4'h6 : 4'h0;
        n_cmd <= n_cmd + 1;
        rst_seen_q <= frst;
        frst <= 1'b0;
      end else if (start_c != 4'h0) begin
        start_c <= start_c - 4'h1;
      end
      raw_q <= fresh ? 32'h0 : (raw_q & ~raw_clr) | (ev_stb ? ev_raw : 32'h0);
    end
  end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench import sdh_pkg::*; ;
  logic core_clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack; // clock, reset, bus control
  logic [7:0] wb_adr, dev_addr; // addresses
  logic [31:0] wb_dat_i, wb_dat_o, dev_wdata, dev_rdata, ev_raw, rx_word, q; // data
  logic [3:0] wb_sel; // byte lanes
  logic dev_req, dev_we, dev_ack, slow, ev_stb; // device port and knobs
  int n_fail, checks, cyc_n, n0; // counters
  localparam logic [31:0] ALL = 32'hFFFF_FFFF; // full compare
  localparam logic [31:0] CM = 32'h8001_5E3F; // command fields under test
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  sdh_ctrl uut (.core_clk(core_clk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_i(wb_dat_i), .wb_sel(wb_sel), .wb_dat_o(wb_dat_o),
    .wb_ack(wb_ack), .dev_req(dev_req), .dev_we(dev_we), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack));
  sdh_card_dev dev (.core_clk(core_clk), .rstn(rstn), .dev_req(dev_req), .dev_we(dev_we),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack),
    .slow(slow), .ev_stb(ev_stb), .ev_raw(ev_raw), .rx_word(rx_word));
  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction
  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle: held until ack is sampled, then released
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_i <= d;
    wb_sel <= s;
    @(posedge core_clk);
    while (wb_ack !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    if (wb_ack !== 1'b1) n_fail++; // no answer within the limit
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    check(q & m, e);
  endtask
  // poll status until the masked bits match, bounded
  task automatic waitst(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    xfer(1'b0, REG_STATUS, 32'h0, 4'hF);
    while ((q & m) !== v && n < 60) begin
      xfer(1'b0, REG_STATUS, 32'h0, 4'hF);
      n++;
    end
    if ((q & m) !== v) n_fail++; // status never settled
  endtask
  // order accepted: wait until it has left
  task automatic order(input logic [31:0] o);
    n0 = dev.n_cmd;
    wr(REG_ORDER, o);
    waitst(b(ST_BUSY), 32'h0);
  endtask
  // order dropped: flag raised, no command reaches the device
  task automatic refuse(input logic [31:0] o);
    n0 = dev.n_cmd;
    wr(REG_ORDER, o);
    rdm(REG_STATUS, b(ST_REFUSED) | b(ST_BUSY), b(ST_REFUSED));
    wr(REG_STATUS, b(ST_REFUSED));
    check(32'(dev.n_cmd - n0), 32'h0);
  endtask
  // one-cycle card side event
  task automatic ev(input logic [31:0] e);
    ev_raw <= e;
    ev_stb <= 1'b1;
    @(posedge core_clk);
    ev_stb <= 1'b0;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {rstn, wb_cyc, wb_stb, wb_we, slow, ev_stb} = '0;
    {wb_adr, wb_dat_i, ev_raw, rx_word, wb_sel} = '0;
    n_fail = 0;
    checks = 0;
    cyc_n = 0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdm(REG_STATUS, ALL, 32'h0);
    rdm(8'h40, ALL, 32'h0);
    slow <= 1'b1;
    wr(REG_ARG, 32'h1234_5678);
    wr(REG_BYTES, 32'h0000_0200);
    wr(REG_BLKSZ, 32'h0000_0040);
    n0 = dev.n_cmd;
    wr(REG_ORDER, 32'h11 | b(OF_DATA) | b(OF_CARD));
    wr(REG_ARG, 32'h0000_0000);
    waitst(b(ST_BUSY), 32'h0);
    rdm(REG_STATUS, b(ST_REFUSED), b(ST_REFUSED));
    wr(REG_STATUS, b(ST_REFUSED));
    check(dev.arg_q, 32'h1234_5678);
    check(dev.blk_q, 32'h0000_0040);
    check(dev.cmd_q & CM, 32'h11 | b(DC_DATA) | b(DC_CARD) | b(DC_START));
    rdm(REG_STATUS, b(ST_BUSY) | b(ST_DATA) | b(ST_CARD), b(ST_DATA) | b(ST_CARD));
    xfer(1'b1, REG_ARG, 32'h0, 4'h3);
    rdm(REG_ARG, ALL, 32'h1234_5678);
    slow <= 1'b0;
    refuse(32'h0D);
    refuse(32'h12 | b(OF_DATA) | b(OF_CARD));
    order(32'h0D | b(OF_CARD));
    check(32'(dev.n_cmd - n0), 32'h1);
    rx_word <= 32'hA5C3_0F96;
    ev(b(DS_RXREQ));
    waitst(b(ST_RXVALID), b(ST_RXVALID));
    rdm(REG_RXW, ALL, 32'hA5C3_0F96);
    rdm(REG_STATUS, b(ST_RXVALID), 32'h0);
    ev(b(DS_DONE));
    waitst(b(ST_DATA), 32'h0);
    rdm(REG_STATUS, b(ST_DONE), b(ST_DONE));
    wr(REG_STATUS, b(ST_DONE));
    check(dev.raw_q & DS_CLR_MASK, 32'h0);
    order(32'h11 | b(OF_DATA));
    ev(b(DS_RTO));
    waitst(b(ST_DATA), 32'h0);
    rdm(REG_STATUS, b(ST_DONE), 32'h0);
    order(32'h12 | b(OF_DATA) | b(OF_ASTOP));
    check(dev.cmd_q & CM, 32'h12 | b(DC_DATA) | b(DC_ASTOP) | b(DC_START));
    ev(b(DS_DRTO));
    waitst(b(ST_DATA), 32'h0);
    rdm(REG_STATUS, b(ST_DTO), b(ST_DTO));
    wr(REG_STATUS, b(ST_DTO));
    order(32'h18 | b(OF_DATA) | b(OF_WRITE) | b(OF_STREAM));
    check(dev.cmd_q & CM, 32'h18 | b(DC_DATA) | b(DC_WRITE) | b(DC_STREAM) | b(DC_START));
    order({26'h0, CMD_GO_IDLE});
    check(dev.cmd_q & (b(DC_STOP) | 32'h3F), b(DC_STOP));
    rdm(REG_STATUS, b(ST_DATA), 32'h0);
    order(32'h35 | b(OF_DATA) | b(OF_RESUME));
    check({31'h0, dev.rst_seen_q}, 32'h1);
    ev(b(DS_SDIO));
    waitst(b(ST_SDIO), b(ST_SDIO));
    rdm(REG_STATUS, b(ST_SDIO) | b(ST_NOSDIO), b(ST_SDIO));
    wr(REG_STATUS, b(ST_SDIO));
    n0 = dev.n_cmd;
    ev(b(DS_EBE) | b(DS_SDIO));
    waitst(b(ST_NOSDIO), b(ST_NOSDIO));
    for (int i = 0; i < 300 && !(dev.n_cmd == n0 + 1 && dev.start_c == 4'h0); i++) begin
      @(posedge core_clk);
    end
    check(dev.cmd_q & (32'h3F | b(DC_STOP)), {26'h0, CMD_STOP} | b(DC_STOP));
    rdm(REG_STATUS, b(ST_SDIO), 32'h0);
    ev(b(DS_DONE));
    waitst(b(ST_DATA), 32'h0);
    refuse(32'h19 | b(OF_DATA) | b(OF_CEATA) | b(OF_STREAM));
    order(32'h19 | b(OF_DATA) | b(OF_CEATA) | b(OF_RWBLK));
    refuse(32'h0D | b(OF_CEATA));
    order(32'h06 | b(OF_CEATA) | b(OF_COMPLETION_SIGNAL_DISABLE));
    check(32'(dev.n_cmd - n0), 32'h1);
    ev(b(DS_DONE));
    waitst(b(ST_DATA), 32'h0);
    order(32'h19 | b(OF_DATA) | b(OF_CEATA) | b(OF_RWBLK) | b(OF_DEVICE_INTERRUPT_DISABLE));
    order(32'h0D | b(OF_CEATA));
    check(32'(dev.n_cmd - n0), 32'h1);
    refuse(32'h0D | b(OF_CEATA) | b(OF_CARD));
    ev(b(DS_DONE));
    waitst(b(ST_DATA), 32'h0);
    order(32'h18 | b(OF_DATA) | b(OF_WRITE) | b(OF_STREAM));
    ev(b(DS_TXSTALL));
    rdm(REG_STATUS, b(ST_DATA), b(ST_DATA));
    wr(REG_ORDER, {26'h0, CMD_STOP});
    wr(REG_TXW, 32'h5A5A_0001);
    waitst(b(ST_BUSY), 32'h0);
    check(dev.tx_q, 32'h5A5A_0001);
    check(dev.clkena & 32'h1, 32'h1);
    check(dev.cmd_q & 32'h3F, {26'h0, CMD_STOP});
    conclude();
  end
endmodule
